// file: rtl/cfrt_core.sv
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`include "cfrt_defs.svh"
module cfrt_core
  import cfrt_pkg::*;
(
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  // avalon-mm slave
  input wire logic [5:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // can side events
  input wire logic DATA_PHASE_IN,
  input wire logic CAN_RX_IN,
  // outputs
  output logic SAMPLE_OUT,
  output logic SAMPLED_BIT_OUT,
  output logic IRQ_OUT
);
  // ==================================================
  // bus decode
  logic [31:0] rdata;
  logic ack;
  wire req = (AVS_READ_IN || AVS_WRITE_IN) && !ack;
  // write lands on the edge that sees waitrequest low
  wire wr = AVS_WRITE_IN && ack;
  wire [3:0] idx = AVS_ADDRESS_IN[5:2];
  wire mapped = (idx <= `CFRT_OFS_EVT);
  wire wr_gc = wr && idx == `CFRT_OFS_GCTRL;
  wire wr_cc = wr && idx == `CFRT_OFS_CCTRL;
  wire wr_nbt = wr && idx == `CFRT_OFS_NBT;
  wire wr_dbt = wr && idx == `CFRT_OFS_DBT;
  wire wr_csts = wr && idx == `CFRT_OFS_CSTS;
  wire wr_cerr = wr && idx == `CFRT_OFS_CERR;
  wire wr_gsts = wr && idx == `CFRT_OFS_GSTS;
  wire wr_fifo = wr && idx == `CFRT_OFS_FIFO;
  wire wr_txb = wr && idx == `CFRT_OFS_TXB;
  wire wr_ists = wr && idx == `CFRT_OFS_ISTS;
  wire wr_imsk = wr && idx == `CFRT_OFS_IMSK;
  wire wr_evt = wr && idx == `CFRT_OFS_EVT;
  // ==================================================
  // registers
  logic [31:0] gctrl;
  logic [31:0] cctrl;
  logic [31:0] nbt;
  logic [31:0] dbt;
  logic [15:0] csts;
  logic [7:0] receive_error_count;
  logic [7:0] transmit_error_count;
  logic [14:0] captured_crc_value;
  logic [14:0] chan_err;
  logic global_halt_flag;
  logic [2:0] gerr;
  logic payload_overflow_flag;
  logic [15:0] timestamp_count;
  logic [7:0] rxfifo;
  logic shared_fifo_enable;
  logic shared_tx_mode;
  logic [7:0] shared_sts;
  logic [15:0] txbuf;
  logic [2:0] ists;
  logic [2:0] imsk;
  wire global_rst = gctrl[`CFRT_GC_RESET];
  wire fd_mode = gctrl[`CFRT_GC_FD];
  wire chan_rst = global_rst || cctrl[`CFRT_CC_RESET];
  wire fifo_clr = shared_tx_mode ? chan_rst : global_rst;
  // ==================================================
  // bit timing
  cfrt_timing_t tim;
  wire use_data = fd_mode && DATA_PHASE_IN;
  wire [31:0] tsel = use_data ? dbt : nbt;
  assign tim = '{prescaler: tsel[25:16], seg_one: tsel[15:8],
                 seg_two: tsel[6:0]};
  logic smp;
  logic bend;
  cfrt_bit_timer u_timer (
    .MCLK_IN(MCLK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .hold_in(chan_rst),
    .timing_in(tim),
    .quantum_out(),
    .sample_out(smp),
    .bit_end_out(bend),
    .seg_out()
  );
  logic rx_s1;
  logic rx_s2;
  always_ff @(posedge MCLK_IN)
  begin
    rx_s1 <= CAN_RX_IN;
    rx_s2 <= rx_s1;
  end
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
      SAMPLED_BIT_OUT <= 1'b1;
    else if (smp)
      SAMPLED_BIT_OUT <= rx_s2;
  end
  assign SAMPLE_OUT = smp;
  // ==================================================
  // control registers
  // timing writes only in channel reset
  wire tim_ok = chan_rst;
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      gctrl <= `CFRT_RST_GCTRL;
      cctrl <= `CFRT_RST_CCTRL;
      nbt <= `CFRT_RST_NBT;
      dbt <= `CFRT_RST_DBT;
    end
    else
    begin
      if (wr_gc)
        gctrl <= {29'h0, AVS_WRITEDATA_IN[2:0]};
      if (wr_cc)
        cctrl <= {30'h0, AVS_WRITEDATA_IN[1:0]};
      else if (global_rst)
        cctrl <= `CFRT_RST_CCTRL;
      if (wr_nbt && tim_ok)
        nbt <= AVS_WRITEDATA_IN;
      if (wr_dbt && tim_ok)
        dbt <= AVS_WRITEDATA_IN;
    end
  end
  // ==================================================
  // channel state
  // clear channel state
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN || chan_rst)
    begin
      csts <= 16'h0000;
      receive_error_count <= 8'h00;
      transmit_error_count <= 8'h00;
      captured_crc_value <= 15'h0000;
      chan_err <= 15'h0000;
      txbuf <= 16'h0000;
    end
    else
    begin
      if (wr_csts)
        csts <= AVS_WRITEDATA_IN[15:0];
      if (wr_cerr)
      begin
        receive_error_count <= AVS_WRITEDATA_IN[7:0];
        transmit_error_count <= AVS_WRITEDATA_IN[15:8];
      end
      if (wr_evt)
      begin
        chan_err <= AVS_WRITEDATA_IN[14:0];
        captured_crc_value <= AVS_WRITEDATA_IN[30:16];
      end
      if (wr_txb)
        txbuf <= AVS_WRITEDATA_IN[15:0];
    end
  end
  // ==================================================
  // global state
  // global only clears
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN || global_rst)
    begin
      global_halt_flag <= 1'b0;
      gerr <= 3'h0;
      payload_overflow_flag <= 1'b0;
      timestamp_count <= 16'h0000;
      rxfifo <= 8'h00;
    end
    else
    begin
      global_halt_flag <= gctrl[`CFRT_GC_HALT];
      if (bend)
        timestamp_count <= timestamp_count + 16'h0001;
      // injected error wins over a clear
      if (wr_evt)
        gerr <= gerr | AVS_WRITEDATA_IN[2:0];
      else if (wr_gsts)
        gerr <= gerr & ~AVS_WRITEDATA_IN[2:0];
      if (wr_gsts)
        rxfifo <= AVS_WRITEDATA_IN[15:8];
      if (!fd_mode)
        payload_overflow_flag <= 1'b0;
      else if (wr_evt && AVS_WRITEDATA_IN[31])
        payload_overflow_flag <= 1'b1;
      else if (wr_gsts && AVS_WRITEDATA_IN[3])
        payload_overflow_flag <= 1'b0;
    end
  end
  // ==================================================
  // shared fifo
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
      shared_tx_mode <= 1'b0;
    else if (wr_fifo)
      shared_tx_mode <= AVS_WRITEDATA_IN[`CFRT_FF_TXMODE];
  end
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN || fifo_clr)
    begin
      shared_fifo_enable <= 1'b0;
      shared_sts <= 8'h00;
    end
    else if (wr_fifo)
    begin
      shared_fifo_enable <= AVS_WRITEDATA_IN[`CFRT_FF_ENABLE];
      shared_sts <= AVS_WRITEDATA_IN[15:8];
    end
  end
  // ==================================================
  // interrupts; set wins over clear
  wire [2:0] ev = {payload_overflow_flag, bend, smp};
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      ists <= 3'h0;
      imsk <= 3'h0;
    end
    else
    begin
      ists <= (ists & ~(wr_ists ? AVS_WRITEDATA_IN[2:0] : 3'h0)) | ev;
      if (wr_imsk)
        imsk <= AVS_WRITEDATA_IN[2:0];
    end
  end
  // a set mask bit blocks its status bit
  assign IRQ_OUT = |(ists & ~imsk);
  // ==================================================
  // read mux and answer, one wait cycle
  always_comb
  begin
    rdata = 32'h0000_0000;
    unique case (idx)
      `CFRT_OFS_GCTRL: rdata = gctrl;
      `CFRT_OFS_CCTRL: rdata = cctrl;
      `CFRT_OFS_NBT: rdata = nbt;
      `CFRT_OFS_DBT: rdata = dbt;
      `CFRT_OFS_CSTS: rdata = {16'h0, csts};
      `CFRT_OFS_CERR: rdata = {16'h0, transmit_error_count,
                               receive_error_count};
      `CFRT_OFS_GSTS: rdata = {16'h0, rxfifo, 3'h0, global_halt_flag,
                               payload_overflow_flag, gerr};
      `CFRT_OFS_TSC: rdata = {16'h0, timestamp_count};
      `CFRT_OFS_FIFO: rdata = {16'h0, shared_sts, 6'h0, shared_tx_mode,
                               shared_fifo_enable};
      `CFRT_OFS_TXB: rdata = {16'h0, txbuf};
      `CFRT_OFS_ISTS: rdata = {29'h0, ists};
      `CFRT_OFS_IMSK: rdata = {29'h0, imsk};
      `CFRT_OFS_EVT: rdata = {1'b0, captured_crc_value, 1'b0, chan_err};
      default: rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      ack <= 1'b0;
      AVS_READDATA_OUT <= 32'h0000_0000;
    end
    else
    begin
      ack <= req;
      if (req)
        AVS_READDATA_OUT <= mapped ? rdata : 32'h0000_0000;
    end
  end
  assign AVS_WAITREQUEST_OUT = !ack;
  // ==================================================
  chan_clear_a:
    assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
      chan_rst |=> receive_error_count == 8'h00 && txbuf == 16'h0000)
    else $error("channel state not cleared");
  fifo_rx_keep_a:
    assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
      (!shared_tx_mode && !global_rst && !wr_fifo) |=>
      $stable(shared_fifo_enable))
    else $error("receive fifo changed without global reset");
  fd_ovf_a:
    assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
      !fd_mode |=> !payload_overflow_flag)
    else $error("overflow flag outside fd mode");
  ts_clear_a:
    assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN)
      global_rst |=> timestamp_count == 16'h0000)
    else $error("timestamp not cleared");
endmodule : cfrt_core

// file: rtl/cfrt_defs.svh
`ifndef CFRT_DEFS_SVH
`define CFRT_DEFS_SVH
// ==================================================
// register word offsets (address bits 5:2)
`define CFRT_OFS_GCTRL 4'h0
`define CFRT_OFS_CCTRL 4'h1
`define CFRT_OFS_NBT 4'h2
`define CFRT_OFS_DBT 4'h3
`define CFRT_OFS_CSTS 4'h4
`define CFRT_OFS_CERR 4'h5
`define CFRT_OFS_GSTS 4'h6
`define CFRT_OFS_TSC 4'h7
`define CFRT_OFS_FIFO 4'h8
`define CFRT_OFS_TXB 4'h9
`define CFRT_OFS_ISTS 4'hA
`define CFRT_OFS_IMSK 4'hB
`define CFRT_OFS_EVT 4'hC
// ==================================================
// field positions
`define CFRT_GC_RESET 0
`define CFRT_GC_FD 1
`define CFRT_GC_HALT 2
`define CFRT_CC_RESET 0
`define CFRT_FF_ENABLE 0
`define CFRT_FF_TXMODE 1
`define CFRT_INT_SAMPLE 0
`define CFRT_INT_BITEND 1
`define CFRT_INT_OVF 2
// ==================================================
// reset values
`define CFRT_RST_NBT 32'h0001_0603
`define CFRT_RST_DBT 32'h0001_0302
`define CFRT_RST_GCTRL 32'h0000_0001
`define CFRT_RST_CCTRL 32'h0000_0001
`endif

// file: rtl/cfrt_pkg.sv
package cfrt_pkg;
  // ==================================================
  // one bit timing set
  typedef struct packed {
    logic [9:0] prescaler;
    logic [7:0] seg_one;
    logic [6:0] seg_two;
  } cfrt_timing_t;
  typedef enum logic [1:0] {
    CFRT_SYNC,
    CFRT_SEG1,
    CFRT_SEG2
  } cfrt_seg_t;
endpackage : cfrt_pkg

// file: rtl/cfrt_bit_timer.sv
`include "cfrt_defs.svh"
module cfrt_bit_timer
  import cfrt_pkg::*;
(
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  // control
  input wire logic hold_in,
  input wire cfrt_timing_t timing_in,
  // events
  output logic quantum_out,
  output logic sample_out,
  output logic bit_end_out,
  output cfrt_seg_t seg_out
);
  // ==================================================
  // prescaler
  logic [9:0] pre_cnt;
  logic [7:0] tq_cnt;
  cfrt_seg_t seg;
  wire tq_tick = !hold_in && (pre_cnt == timing_in.prescaler - 10'h001);
  wire [7:0] seg_last = (seg == CFRT_SEG1) ? timing_in.seg_one - 8'h01 :
                        (seg == CFRT_SEG2) ?
                        {1'b0, timing_in.seg_two} - 8'h01 : 8'h00;
  wire seg_done = tq_tick && (tq_cnt == seg_last);
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN || hold_in || tq_tick)
      pre_cnt <= 10'h000;
    else
      pre_cnt <= pre_cnt + 10'h001;
  end
  // ==================================================
  // segment sequencer
  // sync, seg one, seg two
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN || hold_in)
    begin
      seg <= CFRT_SYNC;
      tq_cnt <= 8'h00;
    end
    else if (seg_done)
    begin
      tq_cnt <= 8'h00;
      unique case (seg)
        CFRT_SYNC: seg <= CFRT_SEG1;
        CFRT_SEG1: seg <= CFRT_SEG2;
        default: seg <= CFRT_SYNC;
      endcase
    end
    else if (tq_tick)
      tq_cnt <= tq_cnt + 8'h01;
  end
  assign quantum_out = tq_tick;
  assign sample_out = seg_done && (seg == CFRT_SEG1);
  assign bit_end_out = seg_done && (seg == CFRT_SEG2);
  assign seg_out = seg;
  // ==================================================
  sync_one_tq_a:
    assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN || hold_in)
      (seg == CFRT_SYNC && tq_tick) |=> seg == CFRT_SEG1)
    else $error("sync segment not one quantum");
  sample_order_a:
    assert property (@(posedge MCLK_IN) disable iff (SYS_RST_IN || hold_in)
      sample_out |=> seg == CFRT_SEG2)
    else $error("sample not followed by segment two");
endmodule : cfrt_bit_timer

// file: tb/cfrt_can_node.sv
// ==================================================
// can bus node seen through a transceiver
module cfrt_can_node
(
  // clock
  input wire logic clk_in,
  // request from the bench
  input wire logic dominant_in,
  // receive line
  output logic rx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // released bus floats back to recessive through the bus termination
  always_ff @(posedge clk_in)
  begin
    rx_out <= ~dominant_in;
  end
endmodule : cfrt_can_node

// file: tb/cfrt_core_bench.sv
`include "cfrt_defs.svh"
module cfrt_core_bench
  import cfrt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic dphase = 1'b0;
  logic dom = 1'b0;
  logic rx;
  logic smp;
  logic sbit;
  logic irq;
  logic [31:0] q;
  int failures = 0;
  int check_count = 0;
  cfrt_can_node node_u (.clk_in(clk), .dominant_in(dom), .rx_out(rx));
  cfrt_core dut_u (.MCLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq),
    .DATA_PHASE_IN(dphase), .CAN_RX_IN(rx), .SAMPLE_OUT(smp),
    .SAMPLED_BIT_OUT(sbit), .IRQ_OUT(irq));
  initial
  begin
    forever #2 clk = ~clk;
  end
  // ==================================================
  // bus and compare
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // values read right after the edge are those sampled at it
  // no cycle count assumed: only the watchdog ends a hung wait
  task automatic bus(input logic w, input logic [5:0] a,
    input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    do
    begin
      @(posedge clk);
    end
    while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // cycles between two sample pulses
  task automatic period(input int e, input string nm);
    int n;
    int t0;
    n = 0;
    t0 = -1;
    while (n < 400)
    begin
      @(posedge clk);
      n++;
      if (smp === 1'b1 && t0 >= 0)
        break;
      if (smp === 1'b1)
        t0 = n;
    end
    chk(nm, e, n - t0);
  endtask : period
  task automatic w(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : w
  task automatic r(input logic [5:0] a, input logic [31:0] m,
    input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask : r
  // ==================================================
  // scenarios
  task automatic t_resetvals();
    r(6'h00, 32'hFFFFFFFF, `CFRT_RST_GCTRL, "gctrl");
    r(6'h04, 32'hFFFFFFFF, `CFRT_RST_CCTRL, "cctrl");
    r(6'h08, 32'hFFFFFFFF, `CFRT_RST_NBT, "nbt");
    r(6'h0C, 32'hFFFFFFFF, `CFRT_RST_DBT, "dbt");
    r(6'h34, 32'hFFFFFFFF, 32'h0, "unmapped");
  endtask : t_resetvals
  task automatic t_timing();
    w(6'h00, 32'h2);
    w(6'h04, 32'h0);
    w(6'h08, 32'h0002_0302);
    r(6'h08, 32'hFFFFFFFF, `CFRT_RST_NBT, "nbt locked");
    period(10, "nominal default");
    w(6'h04, 32'h1);
    w(6'h08, 32'h0002_0302);
    w(6'h0C, 32'h0001_0201);
    w(6'h04, 32'h0);
    period(12, "nominal 2x6");
    dphase <= 1'b1;
    period(4, "data 1x4");
    period(4, "data again");
    dphase <= 1'b0;
    period(12, "nominal back");
    dom <= 1'b1;
    period(12, "dom wait");
    chk("sampled dominant", 32'h0, {31'h0, sbit});
    dom <= 1'b0;
    period(12, "rec wait");
    chk("sampled recessive", 32'h1, {31'h0, sbit});
  endtask : t_timing
  task automatic t_clear();
    w(6'h30, 32'hFFFF_7FFF);
    r(6'h18, 32'hF, 32'hF, "overflow fd");
    w(6'h04, 32'h1);
    r(6'h18, 32'hF, 32'hF, "overflow kept");
    w(6'h00, 32'h6);
    r(6'h18, 32'h10, 32'h10, "halt flag");
    w(6'h04, 32'h0);
    w(6'h20, 32'h3);
    w(6'h04, 32'h1);
    r(6'h20, 32'h1, 32'h0, "tx fifo cleared");
    w(6'h04, 32'h0);
    w(6'h20, 32'h1);
    w(6'h14, 32'h0000_A55A);
    w(6'h10, 32'h0000_1234);
    w(6'h04, 32'h1);
    r(6'h20, 32'h1, 32'h1, "rx fifo kept");
    r(6'h14, 32'hFFFF, 32'h0, "error counts");
    w(6'h00, 32'h3);
    r(6'h20, 32'h1, 32'h0, "rx fifo cleared");
    r(6'h18, 32'h1F, 32'h0, "global errors");
    r(6'h1C, 32'hFFFF, 32'h0, "timestamp");
    r(6'h10, 32'hFFFF, 32'h0, "channel status");
    w(6'h00, 32'h0);
    w(6'h30, 32'h8000_0000);
    r(6'h18, 32'h8, 32'h0, "overflow classic");
  endtask : t_clear
  task automatic t_irq();
    w(6'h00, 32'h2);
    w(6'h04, 32'h0);
    w(6'h2C, 32'h0);
    period(12, "irq wait");
    r(6'h28, 32'h1, 32'h1, "sample event");
    chk("irq on", 32'h1, {31'h0, irq});
    w(6'h2C, 32'h7);
    @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    w(6'h04, 32'h1);
    w(6'h28, 32'h7);
    w(6'h2C, 32'h0);
    r(6'h28, 32'h7, 32'h0, "events cleared");
    chk("irq off", 32'h0, {31'h0, irq});
  endtask : t_irq
  // ==================================================
  // verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_resetvals();
    t_timing();
    t_clear();
    t_irq();
    test_done();
  end
  // whole run needs a few hundred cycles
  initial
  begin
    #100000;
    failures++;
    test_done();
  end
endmodule : cfrt_core_bench
